// File: core/bct_fifo.v
/*
  Synchronous request queue with valid and ready on both sides, a fill
  level output and a flush input. Assumes one clock and a synchronous,
  active-high reset; flush empties the queue at the next edge.
*/
`default_nettype none

module bct_fifo #(
  parameter WIDTH = 44,
  parameter DEPTH = 8,
  parameter LVL_W = 4
) (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // occupancy
  output wire [LVL_W-1:0] level
);

  // pointer width derived from depth
  function integer bct_clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      bct_clog2 = 0;
      while (v > 0) begin
        v = v >> 1;
        bct_clog2 = bct_clog2 + 1;
      end
    end
  endfunction

  localparam AW = (DEPTH > 1) ? bct_clog2(DEPTH) : 1;

  reg [WIDTH-1:0] store [0:DEPTH-1]; // queue storage
  reg [AW-1:0] wr_ptr_reg; // next slot to fill
  reg [AW-1:0] rd_ptr_reg; // oldest slot
  reg [LVL_W-1:0] count_reg; // words held

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // honest flags straight from the count
  assign in_ready = (count_reg != DEPTH[LVL_W-1:0]);
  assign out_valid = (count_reg != {LVL_W{1'b0}});
  assign out_data = store[rd_ptr_reg];
  assign level = count_reg;

  // pointer advance with wrap at depth
  function [AW-1:0] bct_ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1) begin
        bct_ptr_inc = {AW{1'b0}};
      end else begin
        bct_ptr_inc = p + 1'b1;
      end
    end
  endfunction

  // storage write; no reset needed, contents are guarded by the count
  always @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {LVL_W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= bct_ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bct_ptr_inc(rd_ptr_reg);
      end
      // simultaneous push and pop leaves the count alone
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: core/bct_map.vh
/*
  Constants for the bus cycle termination slave: data path widths, the
  size of the local word store, the request queue depth and reset values.
  Assumes it is included by bare name from the design files under core/.
*/
`ifndef BCT_MAP_VH
`define BCT_MAP_VH

// bus data path
`define BCT_DAT_W 32
`define BCT_SEL_W 4
// one byte lane per select bit
`define BCT_BYTE_W 8
`define BCT_ADR_W 5
// address tag extends the word address by one bit
`define BCT_EXT_W 6
// local word store: words below this effective address exist
`define BCT_MEM_WORDS 32
`define BCT_MEM_AW 5

// packed request word: {we, tga, adr, sel, dat, tgd}
`define BCT_REQ_W 44
`define BCT_REQ_WE 43
`define BCT_REQ_TGA 42
`define BCT_REQ_ADR_HI 41
`define BCT_REQ_ADR_LO 37
`define BCT_REQ_SEL_HI 36
`define BCT_REQ_SEL_LO 33
`define BCT_REQ_DAT_HI 32
`define BCT_REQ_DAT_LO 1
`define BCT_REQ_TGD 0

// request queue
`define BCT_FIFO_DEPTH 8
`define BCT_FIFO_LVL_W 4
// stall is raised when this many slots are taken, leaving one slot of
// slack for the request that the master presents while stall rises
`define BCT_STALL_LVL 4'h7

// reset values
`define BCT_TERM_RST 1'b0
`define BCT_DAT_RST 32'h0000_0000

`endif

// File: core/bct_slave.v
/*
  Bus slave with a small word store and full cycle termination logic:
  acknowledge, error and retry, standard and pipelined traffic, stall,
  and address, data and cycle tags. Assumes one clock, a synchronous
  active-high reset, and a master that keeps its own side of the bus
  handshake. All outputs are registered.
*/
// What this block does
// - error terminates faulty access instead of acknowledge
// - retry terminates standard access while resource is busy; pipelined access is stalled instead
// - at most one termination asserted at once
// - standard terminations rise one edge after strobe and drop at the next edge; pipelined ones follow the queue drain
// - terminations are registered only, never combinational
// - acknowledge is never held high; it is registered, costing one wait state
// - N pipelined requests get N terminations, acknowledge or error
// - pipelined read data valid with acknowledge
// - read accepted on cyc, stb, no stall, no we
// - write accepted on cyc, stb, we, no stall
// - output data valid only with a termination
// - every sideband tag has a defined tag type
// - tags follow address, data word or cycle
// - standard terminations derive from cyc and stb
// - bus inputs ignored while cycle is low
`default_nettype none
`include "bct_map.vh"

module bct_slave (
  // clock and reset
  input wire clk,
  input wire reset,
  // traffic mode, taken when no cycle is open (high selects pipelined)
  input wire pipe_mode,
  // local resource busy: retry in standard mode, drain stall when pipelined
  input wire busy,
  // request from the master
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [`BCT_ADR_W-1:0] adr_i,
  input wire [`BCT_DAT_W-1:0] dat_i,
  input wire [`BCT_SEL_W-1:0] sel_i,
  // tags: address tag, input data tag, cycle tag
  input wire tga_i,
  input wire tgd_i,
  input wire tgc_i,
  // answer to the master
  output wire ack_o,
  output wire err_o,
  output wire rty_o,
  output wire stall_o,
  output wire [`BCT_DAT_W-1:0] dat_o,
  output wire tgd_o
);

  // local word store with one data tag bit per word
  reg [`BCT_DAT_W-1:0] mem [0:`BCT_MEM_WORDS-1];
  reg mem_tag [0:`BCT_MEM_WORDS-1];

  // output flops
  reg ack_reg;
  reg err_reg;
  reg rty_reg;
  reg stall_reg;
  reg [`BCT_DAT_W-1:0] dat_reg;
  reg tgd_reg;

  // cycle context
  reg cyc_open_reg; // a cycle has been seen open
  reg mode_pipe_reg; // mode frozen for the open cycle
  reg ro_cycle_reg; // cycle tag: cycle is read only

  // queue signals; only pipelined requests pass through the queue,
  // standard traffic is answered straight from the bus lines
  wire [`BCT_REQ_W-1:0] q_in;
  wire [`BCT_REQ_W-1:0] q_out;
  wire q_in_ready;
  wire q_out_valid;
  wire q_out_ready;
  wire [`BCT_FIFO_LVL_W-1:0] q_level;
  wire q_flush;

  // combinational execute stage
  // at most one request is executed per edge, from the queue or the bus
  reg exec_go;
  reg exec_term_ok;
  reg exec_busy;
  reg exec_we;
  reg [`BCT_EXT_W-1:0] exec_ext_adr;
  reg [`BCT_SEL_W-1:0] exec_sel;
  reg [`BCT_DAT_W-1:0] exec_dat;
  reg exec_tgd;
  reg exec_fault;
  reg ack_next;
  reg err_next;
  reg rty_next;
  reg stall_next;

  // address and data tags travel with their words
  // mode and cycle tag come from the frozen context once the cycle is open
  wire mode_pipe = cyc_open_reg ? mode_pipe_reg : pipe_mode;
  wire ro_cycle = cyc_open_reg ? ro_cycle_reg : tgc_i;
  wire term_any = ack_reg || err_reg || rty_reg;

  // merge write data into a word under byte enables
  function [`BCT_DAT_W-1:0] bct_merge;
    input [`BCT_DAT_W-1:0] old_word;
    input [`BCT_DAT_W-1:0] new_word;
    input [`BCT_SEL_W-1:0] sel;
    integer b;
    begin
      bct_merge = old_word;
      for (b = 0; b < `BCT_SEL_W; b = b + 1) begin
        if (sel[b]) begin
          bct_merge[b*`BCT_BYTE_W +: `BCT_BYTE_W] = new_word[b*`BCT_BYTE_W +: `BCT_BYTE_W];
        end
      end
    end
  endfunction

  // a word address outside the store, or a write in a read-only cycle
  function bct_fault;
    input [`BCT_EXT_W-1:0] ext_adr;
    input we;
    input ro;
    begin
      bct_fault = (ext_adr >= `BCT_MEM_WORDS) || (we && ro);
    end
  endfunction

  // word index into the store; the address tag bit is dropped here
  // because a faulting address never reaches the store
  function [`BCT_MEM_AW-1:0] bct_word;
    input [`BCT_EXT_W-1:0] ext_adr;
    begin
      bct_word = ext_adr[`BCT_MEM_AW-1:0];
    end
  endfunction

  // pipelined acceptance: fields are sampled only together with strobe
  // stall is taken from the flop the master sees, so both agree on a take
  wire accept = cyc_i && stb_i && mode_pipe && !stall_reg;

  assign q_in = {we_i, tga_i, adr_i, sel_i, dat_i, tgd_i};
  // queue drains one request per cycle unless the resource is busy;
  // busy back-pressure fills the queue and in turn raises stall
  assign q_out_ready = cyc_i && mode_pipe && !busy;
  // dropping the cycle discards queued work, so no late acknowledges
  // trade-off: a master that drops the cycle early loses its requests
  assign q_flush = !cyc_i;

  bct_fifo #(
    .WIDTH(`BCT_REQ_W),
    .DEPTH(`BCT_FIFO_DEPTH),
    .LVL_W(`BCT_FIFO_LVL_W)
  ) u_queue (
    .clk(clk),
    .reset(reset),
    .flush(q_flush),
    .in_valid(accept),
    .in_ready(q_in_ready),
    .in_data(q_in),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out),
    .level(q_level)
  );

  // choose the request to execute this cycle and its termination
  always @* begin
    exec_go = 1'b0;
    exec_busy = 1'b0;
    exec_we = 1'b0;
    exec_ext_adr = {`BCT_EXT_W{1'b0}};
    exec_sel = {`BCT_SEL_W{1'b0}};
    exec_dat = {`BCT_DAT_W{1'b0}};
    exec_tgd = 1'b0;
    if (!cyc_i) begin
      // nothing on the bus is looked at without a cycle
      exec_go = 1'b0;
    end else if (mode_pipe) begin
      // oldest queued request first keeps answers in order
      exec_go = q_out_valid && q_out_ready;
      exec_we = q_out[`BCT_REQ_WE];
      exec_ext_adr = {q_out[`BCT_REQ_TGA], q_out[`BCT_REQ_ADR_HI:`BCT_REQ_ADR_LO]};
      exec_sel = q_out[`BCT_REQ_SEL_HI:`BCT_REQ_SEL_LO];
      exec_dat = q_out[`BCT_REQ_DAT_HI:`BCT_REQ_DAT_LO];
      exec_tgd = q_out[`BCT_REQ_TGD];
    end else begin
      // standard: one registered answer per strobe, then a gap so the
      // termination drops again before the next strobe
      exec_go = stb_i && !term_any;
      exec_busy = busy;
      exec_we = we_i;
      exec_ext_adr = {tga_i, adr_i};
      exec_sel = sel_i;
      exec_dat = dat_i;
      exec_tgd = tgd_i;
    end
    exec_fault = bct_fault(exec_ext_adr, exec_we, ro_cycle);
    exec_term_ok = exec_go && !exec_busy && !exec_fault;
  end

  // termination select: priority retry, then error, then acknowledge,
  // so never more than one is raised
  always @* begin
    rty_next = exec_go && exec_busy;
    err_next = exec_go && !exec_busy && exec_fault;
    ack_next = exec_term_ok;
  end

  // limitation: once the queue fills while busy holds the drain, stall stays high until busy falls and the level drains below 7
  // stall registered from the queue level; one slot of slack covers the
  // request presented in the cycle stall rises
  always @* begin
    stall_next = 1'b0;
    if (cyc_i && mode_pipe) begin
      if (q_level >= `BCT_STALL_LVL) begin
        stall_next = 1'b1;
      end else if (!q_in_ready) begin
        stall_next = 1'b1;
      end
    end
  end

  // registered terminations cost one wait state but keep outputs on
  // flops; a held acknowledge is not offered since wait states exist
  always @(posedge clk) begin
    if (reset) begin
      ack_reg <= `BCT_TERM_RST;
      err_reg <= `BCT_TERM_RST;
      rty_reg <= `BCT_TERM_RST;
      stall_reg <= `BCT_TERM_RST;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      rty_reg <= rty_next;
      stall_reg <= stall_next;
    end
  end

  // read data and its tag only stand beside a termination, else zero
  always @(posedge clk) begin
    if (reset) begin
      dat_reg <= `BCT_DAT_RST;
      tgd_reg <= 1'b0;
    end else if (exec_term_ok && !exec_we) begin
      dat_reg <= mem[bct_word(exec_ext_adr)];
      tgd_reg <= mem_tag[bct_word(exec_ext_adr)];
    end else begin
      dat_reg <= `BCT_DAT_RST;
      tgd_reg <= 1'b0;
    end
  end

  // store writes; the store holds no reset state of its own
  // a word read before its first write returns unknown data
  always @(posedge clk) begin
    if (exec_term_ok && exec_we) begin
      mem[bct_word(exec_ext_adr)] <=
        bct_merge(mem[bct_word(exec_ext_adr)], exec_dat, exec_sel);
      mem_tag[bct_word(exec_ext_adr)] <= exec_tgd;
    end
  end

  // a cycle open for a single edge is enough to latch its mode
  // cycle context: mode and cycle tag frozen at the cycle's first edge
  // so a mid-cycle change cannot split the answer stream
  always @(posedge clk) begin
    if (reset) begin
      cyc_open_reg <= 1'b0;
      mode_pipe_reg <= 1'b0;
      ro_cycle_reg <= 1'b0;
    end else if (!cyc_i) begin
      cyc_open_reg <= 1'b0;
    end else if (!cyc_open_reg) begin
      cyc_open_reg <= 1'b1;
      mode_pipe_reg <= pipe_mode;
      ro_cycle_reg <= tgc_i;
    end
  end

  // outputs straight from flops
  // keeps the long return path to the master free of logic
  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign rty_o = rty_reg;
  assign stall_o = stall_reg;
  assign dat_o = dat_reg;
  assign tgd_o = tgd_reg;

endmodule

`default_nettype wire

// File: sim/bct_chk.sv
/*
  Checker for the bus slave termination outputs.
  Assumes it is bound to bct_slave, with one clock and a synchronous reset.
*/
`default_nettype none
`include "bct_map.vh"
module bct_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request side
  input wire logic pipe_mode,
  input wire logic busy,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic tga_i,
  // answer side
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic rty_o,
  input wire logic stall_o,
  input wire logic [`BCT_DAT_W-1:0] dat_o,
  input wire logic tgd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic term = ack_o | err_o | rty_o; // any termination
  logic [4:0] pend_reg; // taken but unanswered; dropping the cycle forgets them
  always_ff @(posedge clk) begin
    if (reset || !cyc_i)
      pend_reg <= 5'h00;
    else
      pend_reg <= pend_reg + 5'(stb_i && !stall_o) - 5'(ack_o || err_o);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  one_term_a: assert property ($onehot0({ack_o, err_o, rty_o}))
    else $error("two terminations at once");
  std_cause_a: assert property (!pipe_mode && term |-> $past(cyc_i && stb_i))
    else $error("termination without strobe");
  std_answer_a: assert property (!pipe_mode && cyc_i && stb_i && !term |=> term)
    else $error("strobe not terminated");
  rty_busy_a: assert property (!pipe_mode && cyc_i && stb_i && busy && !term |=> rty_o)
    else $error("busy without retry");
  err_tag_a: assert property (!pipe_mode && cyc_i && stb_i && !busy && tga_i && !term |=> err_o)
    else $error("bad address without error");
  dat_qual_a: assert property (!ack_o |-> dat_o == `BCT_DAT_RST && !tgd_o)
    else $error("data outside acknowledge");
  idle_quiet_a: assert property (!cyc_i && !$past(cyc_i) |-> !term)
    else $error("answer while cycle low");
  pipe_count_a: assert property (pipe_mode && cyc_i && (ack_o || err_o) |-> pend_reg != 5'h00)
    else $error("answer without request");
  term_drop_a: assert property (!pipe_mode && term |=> !term)
    else $error("termination held past one cycle");
  stall_idle_a: assert property (!cyc_i |=> !stall_o)
    else $error("stall without cycle");
endmodule
bind bct_slave bct_chk u_chk (
  .clk(clk), .reset(reset), .pipe_mode(pipe_mode), .busy(busy), .cyc_i(cyc_i),
  .stb_i(stb_i), .tga_i(tga_i), .ack_o(ack_o), .err_o(err_o), .rty_o(rty_o),
  .stall_o(stall_o), .dat_o(dat_o), .tgd_o(tgd_o)
);
`default_nettype wire

// File: sim/bct_mst.sv
/*
  Bus master model, standard and pipelined.
  Assumes one clock; it changes its lines only at falling edges.
*/
`default_nettype none
`include "bct_map.vh"
module bct_mst (
  // clock and answers
  input wire logic clk,
  input wire logic ack,
  input wire logic err,
  input wire logic rty,
  input wire logic stall,
  input wire logic [`BCT_DAT_W-1:0] rdat,
  input wire logic rtag,
  // request lines
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [`BCT_ADR_W-1:0] adr,
  output logic [`BCT_DAT_W-1:0] dat,
  output logic [`BCT_SEL_W-1:0] sel,
  output logic tga,
  output logic tgd,
  output logic tgc
);
  timeunit 1ns;
  timeprecision 1ps;
  // burst requests, filled by the bench
  logic q_we[16];
  logic q_tga[16];
  logic [4:0] q_adr[16];
  logic [31:0] q_dat[16];
  // answers in arrival order: 1 ack, 2 error
  logic [1:0] r_k[16];
  logic [31:0] r_d[16];
  logic r_t[16];
  initial {cyc, stb, we, adr, dat, sel, tga, tgd, tgc} = '0;
  // invert qualified lines so a stale request never looks valid
  task automatic junk();
    stb = 1'b0;
    {we, adr, dat, sel, tga, tgd, tgc} = ~{we, adr, dat, sel, tga, tgd, tgc};
  endtask
  task automatic put(input logic w, g, c, t, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] s);
    {cyc, stb, we, tga, tgc, tgd, adr, dat, sel} = {2'h3, w, g, c, t, a, d, s};
  endtask
  // one standard transfer; the request stands across the edge that sees the answer
  task automatic single(input logic w, g, c, t, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] k, output logic [31:0] rd, output logic rt);
    k = 2'h0;
    @(negedge clk);
    put(w, g, c, t, a, d, s);
    // strobe watchdog: a hung strobe is abandoned with k left at 0
    for (int i = 0; i < 20 && k == 2'h0; i++) begin
      @(negedge clk);
      k = ack ? 2'h1 : err ? 2'h2 : rty ? 2'h3 : 2'h0;
      rd = rdat;
      rt = rtag;
    end
    @(negedge clk);
    junk();
    cyc = 1'b0;
  endtask
  // pipelined burst: no waiting for answers, hold while stalled
  task automatic burst(input int n, output int got);
    int i;
    i = 0;
    got = 0;
    for (int c = 0; c < 400 && got < n; c++) begin
      @(negedge clk);
      if (ack | err) begin
        r_k[got] = ack ? 2'h1 : 2'h2;
        r_d[got] = rdat;
        r_t[got] = rtag;
        got++;
      end
      if (i < n) begin
        put(q_we[i], q_tga[i], 1'b0, q_adr[i][0], q_adr[i], q_dat[i], 4'hf);
        i += int'(!stall);
      end else
        junk();
    end
    @(negedge clk);
    cyc = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/bct_slave_tb.sv
/*
  Testbench for the bus slave: standard, pipelined and stalled traffic.
  Assumes the master model and checker files compile first.
*/
`default_nettype none
module bct_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, pipe_mode, busy;
  logic cyc, stb, we, tga, tgd, tgc, ack, err, rty, stall, rtag;
  logic [4:0] adr;
  logic [31:0] dat, rdat;
  logic [3:0] sel;
  int error_cnt = 0;
  int tests_run = 0;
  bct_slave u_dut (.clk(clk), .reset(reset), .pipe_mode(pipe_mode), .busy(busy),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel),
    .tga_i(tga), .tgd_i(tgd), .tgc_i(tgc), .ack_o(ack), .err_o(err), .rty_o(rty),
    .stall_o(stall), .dat_o(rdat), .tgd_o(rtag));
  // stall reaches the master model straight, with no register
  bct_mst u_mst (.clk(clk), .ack(ack), .err(err), .rty(rty), .stall(stall), .rdat(rdat),
    .rtag(rtag), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(dat), .sel(sel),
    .tga(tga), .tgd(tgd), .tgc(tgc));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // byte merge, tags, error and retry in standard mode
  task automatic t_std();
    logic [1:0] k;
    logic [31:0] d;
    logic t;
    u_mst.single(1'b1, 1'b0, 1'b0, 1'b1, 5'h03, 32'h1122_3344, 4'hf, k, d, t);
    chk("wr ack", k, 32'h1);
    u_mst.single(1'b1, 1'b0, 1'b0, 1'b0, 5'h03, 32'haabb_ccdd, 4'h2, k, d, t);
    u_mst.single(1'b0, 1'b0, 1'b0, 1'b1, 5'h03, 32'h0, 4'hf, k, d, t);
    chk("rd ack", k, 32'h1);
    chk("rd word", d, 32'h1122_cc44);
    chk("rd tag", t, 32'h0);
    u_mst.single(1'b0, 1'b1, 1'b0, 1'b0, 5'h03, 32'h0, 4'hf, k, d, t);
    chk("tag err", k, 32'h2);
    u_mst.single(1'b1, 1'b0, 1'b1, 1'b0, 5'h03, 32'h0, 4'hf, k, d, t);
    chk("ro err", k, 32'h2);
    busy = 1'b1;
    u_mst.single(1'b0, 1'b0, 1'b0, 1'b0, 5'h03, 32'h0, 4'hf, k, d, t);
    chk("retry", k, 32'h3);
    busy = 1'b0;
    $display("test std done");
  endtask
  // back to back writes then reads, one bad address among the reads
  task automatic t_pipe();
    int n, o;
    for (int i = 0; i < 9; i++) begin
      o = i < 4 ? i : i > 5 ? i - 5 : 0;
      u_mst.q_we[i] = i < 4;
      u_mst.q_tga[i] = i == 5;
      u_mst.q_adr[i] = 5'(8 + o);
      u_mst.q_dat[i] = 32'ha0 + o;
    end
    pipe_mode = 1'b1;
    u_mst.burst(9, n);
    chk("answers", n, 32'h9);
    for (int i = 0; i < 9; i++) begin
      o = i > 3 && i != 5 ? (i < 5 ? 0 : i - 5) : -1;
      chk("kind", u_mst.r_k[i], i == 5 ? 32'h2 : 32'h1);
      chk("data", u_mst.r_d[i], o < 0 ? 32'h0 : 32'ha0 + o);
      chk("dtag", u_mst.r_t[i], o < 0 ? 32'h0 : o % 2);
    end
    pipe_mode = 1'b0;
    $display("test pipe done");
  endtask
  // queue fills while drain is blocked, then empties
  task automatic t_stall();
    int n;
    logic [1:0] k;
    logic [31:0] d;
    logic t;
    for (int i = 0; i < 12; i++) begin
      u_mst.q_we[i] = 1'b1;
      u_mst.q_tga[i] = 1'b0;
      u_mst.q_adr[i] = 5'(16 + i);
      u_mst.q_dat[i] = 32'hb0 + i;
    end
    pipe_mode = 1'b1;
    busy = 1'b1;
    fork
      u_mst.burst(12, n);
      begin
        repeat (20) @(negedge clk);
        chk("stall", stall, 32'h1);
        busy = 1'b0;
      end
    join
    chk("drained", n, 32'hc);
    pipe_mode = 1'b0;
    u_mst.single(1'b0, 1'b0, 1'b0, 1'b0, 5'h1b, 32'h0, 4'hf, k, d, t);
    chk("last ack", k, 32'h1);
    chk("last word", d, 32'hbb);
    $display("test stall done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {reset, pipe_mode, busy} = 3'b100;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk("reset", {stall, ack, err, rty}, 32'h0);
    t_std();
    t_pipe();
    t_stall();
    tally_and_finish();
  end
endmodule
`default_nettype wire
